//--- pkg/rdc_regs.vh
// Purpose: offsets, field positions and reset values for the direction
//          and clock select block
// Assumes: byte addresses on a 32-bit AHB-Lite slave, one word each
// Notes:   definitions only
`ifndef RDC_REGS_VH
`define RDC_REGS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define RDC_CTRL_OFF 8'h00
`define RDC_DIVISOR_OFF 8'h04
`define RDC_TXDATA_OFF 8'h08
`define RDC_RXDATA_OFF 8'h0C
`define RDC_STATUS_OFF 8'h10

// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define RDC_CTRL_AUTO 0
`define RDC_CTRL_REQ 1
`define RDC_CTRL_NOECHO 2
`define RDC_CTRL_UNDIVIDED_CLOCK_SETTING 3
`define RDC_CTRL_DIV4 4
`define RDC_CTRL_RTS 5
`define RDC_CTRL_RST 6'h10
`define RDC_DIVISOR_RST 16'h0001

// ---------------------------------------------------------------
// status fields
// ---------------------------------------------------------------
`define RDC_ST_TXBUSY 0
`define RDC_ST_DRVEN 1
`define RDC_ST_RXVALID 2
`define RDC_ST_OVERRUN 3
`define RDC_ST_FRAMEERR 4
`define RDC_ST_CLKBAD 5
`define RDC_ST_FULL 6
`define RDC_ST_EMPTY 7

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define RDC_PRESCALE_FOUR 4
`define RDC_OVERSAMPLE 16

`endif

//--- src/rdc_fifo.v
// Purpose: small flip-flop fifo, valid/ready on both sides
// Assumes: DEPTH is a power of two, AW = log2(DEPTH)
// Notes:   no bypass; a word written is visible the next cycle
`timescale 1ns/1ns
module rdc_fifo #(
    parameter W = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire clk_i,
    input wire arst_n_i,
    // fill side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [W-1:0] in_data_i,
    // drain side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [W-1:0] out_data_o,
    // level
    output wire [AW:0] count_o
);

    reg [W-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;

    assign in_ready_o = (count_reg != DEPTH[AW:0]);
    assign out_valid_o = (count_reg != {(AW+1){1'b0}});
    assign out_data_o = mem_reg[rd_ptr_reg];
    assign count_o = count_reg;
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always @(posedge clk_i)
    begin
        if (push)
            mem_reg[wr_ptr_reg] <= in_data_i;
    end

    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (push & ~pop)
                count_reg <= count_reg + 1'b1;
            else if (pop & ~push)
                count_reg <= count_reg - 1'b1;
        end
    end

endmodule // rdc_fifo

//--- src/rdc_top.v
// Purpose: line driver direction, echo control and baud prescale for a
//          differential serial port, with a tiny 8N1 serial engine
// Assumes: one 100 MHz clock, AHB-Lite single word transfers
// Notes:
`timescale 1ns/1ns
`include "rdc_regs.vh"
module rdc_top #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3
) (
    // clock and reset
    input wire CLK_I,
    input wire ARST_N_I,
    // ahb-lite slave
    input wire HSEL_I,
    input wire [31:0] HADDR_I,
    input wire [1:0] HTRANS_I,
    input wire HWRITE_I,
    input wire [2:0] HSIZE_I,
    input wire [31:0] HWDATA_I,
    input wire HREADY_I,
    output wire [31:0] HRDATA_O,
    output wire HREADYOUT_O,
    output wire HRESP_O,
    // serial line
    output wire TXD_O,
    output wire DRV_EN_O,
    input wire RXD_I,
    output wire RX_EN_O,
    output wire RTS_O,
    output wire BAUD_REF_EN_O
);

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    localparam IDX_CTRL = 3'd0;
    localparam IDX_DIV = 3'd1;
    localparam IDX_TX = 3'd2;
    localparam IDX_RX = 3'd3;
    localparam IDX_STAT = 3'd4;
    localparam IDX_NONE = 3'd7;

    function [2:0] reg_index;
        input [31:0] addr;
        begin
            case (addr[7:0])
                `RDC_CTRL_OFF: reg_index = IDX_CTRL;
                `RDC_DIVISOR_OFF: reg_index = IDX_DIV;
                `RDC_TXDATA_OFF: reg_index = IDX_TX;
                `RDC_RXDATA_OFF: reg_index = IDX_RX;
                `RDC_STATUS_OFF: reg_index = IDX_STAT;
                default: reg_index = IDX_NONE;
            endcase
            if (addr[31:8] != 24'h00_0000)
                reg_index = IDX_NONE;
        end
    endfunction

    // ---------------------------------------------------------------
    // state declarations
    // ---------------------------------------------------------------
    localparam ST_IDLE = 4'b0001;
    localparam ST_START = 4'b0010;
    localparam ST_DATA = 4'b0100;
    localparam ST_STOP = 4'b1000;

    reg [5:0] ctrl_reg;
    reg [15:0] divisor_reg;
    reg dp_valid_reg;
    reg dp_write_reg;
    reg [2:0] dp_idx_reg;
    reg [31:0] hrdata_reg;
    reg [31:0] hrdata_next;
    reg [1:0] pre_cnt_reg;
    reg [3:0] tx_state_reg;
    reg [20:0] tx_cnt_reg;
    reg [2:0] tx_bit_reg;
    reg [7:0] tx_shift_reg;
    reg txd_reg;
    reg rx_s1_reg;
    reg rx_s2_reg;
    reg rx_prev_reg;
    reg [3:0] rx_state_reg;
    reg [20:0] rx_cnt_reg;
    reg [2:0] rx_bit_reg;
    reg [7:0] rx_shift_reg;
    reg [7:0] rx_data_reg;
    reg rx_valid_reg;
    reg overrun_reg;
    reg frame_err_reg;

    wire a_take;
    wire [2:0] a_idx;
    wire wr_done;
    wire fifo_in_valid;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire [7:0] fifo_out_data;
    wire [FIFO_AW:0] fifo_count;
    wire div_one;
    wire div_four;
    wire clk_ok;
    wire ref_en;
    wire [15:0] div_eff;
    wire [20:0] bit_len;
    wire [20:0] half_len;
    wire tx_tick;
    wire tx_busy;
    wire drv_en;
    wire rx_en;
    wire rx_tick;
    wire rx_read;
    wire rx_done;
    wire [31:0] status_word;

    // ---------------------------------------------------------------
    // ahb-lite slave
    // ---------------------------------------------------------------
    assign a_take = HSEL_I & HTRANS_I[1] & HREADY_I;
    assign a_idx = reg_index(HADDR_I);
    // a full fifo stalls the bus instead of dropping the byte
    assign HREADYOUT_O = ~(dp_valid_reg & dp_write_reg &
        (dp_idx_reg == IDX_TX) & ~fifo_in_ready);
    assign HRESP_O = 1'b0;
    assign HRDATA_O = hrdata_reg;
    assign wr_done = dp_valid_reg & dp_write_reg & HREADYOUT_O;
    assign rx_read = a_take & ~HWRITE_I & (a_idx == IDX_RX);

    always @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_idx_reg <= IDX_NONE;
            hrdata_reg <= 32'h0000_0000;
        end
        else if (HREADY_I)
        begin
            dp_valid_reg <= a_take;
            dp_write_reg <= HWRITE_I;
            dp_idx_reg <= a_idx;
            if (a_take & ~HWRITE_I)
                hrdata_reg <= hrdata_next;
        end
    end

    // count field is four bits; a deeper fifo needs a wider map
    assign status_word = {20'h0_0000, fifo_count[3:0],
        ~fifo_out_valid, ~fifo_in_ready, ~clk_ok, frame_err_reg,
        overrun_reg, rx_valid_reg, drv_en, tx_busy};

    always @*
    begin
        case (a_idx)
            IDX_CTRL: hrdata_next = {26'h000_0000, ctrl_reg};
            IDX_DIV: hrdata_next = {16'h0000, divisor_reg};
            IDX_RX: hrdata_next = {24'h00_0000, rx_data_reg};
            IDX_STAT: hrdata_next = status_word;
            default: hrdata_next = 32'h0000_0000;
        endcase
    end

    always @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            ctrl_reg <= `RDC_CTRL_RST;
            divisor_reg <= `RDC_DIVISOR_RST;
        end
        else if (wr_done)
        begin
            if (dp_idx_reg == IDX_CTRL)
                ctrl_reg <= HWDATA_I[5:0];
            if (dp_idx_reg == IDX_DIV)
                divisor_reg <= HWDATA_I[15:0];
        end
    end

    // ---------------------------------------------------------------
    // transmit fifo
    // ---------------------------------------------------------------
    assign fifo_in_valid = dp_valid_reg & dp_write_reg &
        (dp_idx_reg == IDX_TX);

    rdc_fifo #(
        .W(8),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_tx_fifo (
        .clk_i(CLK_I),
        .arst_n_i(ARST_N_I),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(HWDATA_I[7:0]),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data),
        .count_o(fifo_count)
    );

    // ---------------------------------------------------------------
    // baud reference prescale
    // ---------------------------------------------------------------
    localparam PRE_LAST = `RDC_PRESCALE_FOUR - 1;
    assign div_one = ctrl_reg[`RDC_CTRL_UNDIVIDED_CLOCK_SETTING];
    assign div_four = ctrl_reg[`RDC_CTRL_DIV4];
    // both or neither selected: reference stops, no garbage rate
    assign clk_ok = div_one ^ div_four;
    assign ref_en = clk_ok & (div_one |
        (pre_cnt_reg == PRE_LAST[1:0]));
    assign BAUD_REF_EN_O = ref_en;

    always @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            pre_cnt_reg <= 2'b00;
        else if (!clk_ok || div_one)
            pre_cnt_reg <= 2'b00;
        else
            pre_cnt_reg <= pre_cnt_reg + 1'b1;
    end

    // divisor 0 behaves as 1 to keep the bit period nonzero
    assign div_eff = (divisor_reg == 16'h0000) ? 16'h0001 : divisor_reg;
    // bit period in reference ticks; undivided_clock_setting is four times faster
    assign bit_len = {1'b0, div_eff, 4'h0};
    assign half_len = {1'b0, bit_len[20:1]};

    // ---------------------------------------------------------------
    // transmitter
    // ---------------------------------------------------------------
    assign tx_tick = ref_en & (tx_cnt_reg == bit_len - 21'd1);
    assign tx_busy = (tx_state_reg != ST_IDLE);
    // next byte is taken straight from stop, so enable never dips
    assign fifo_out_ready = clk_ok & ((tx_state_reg == ST_IDLE) |
        ((tx_state_reg == ST_STOP) & tx_tick));
    assign TXD_O = txd_reg;

    always @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            tx_state_reg <= ST_IDLE;
            tx_cnt_reg <= 21'd0;
            tx_bit_reg <= 3'd0;
            tx_shift_reg <= 8'h00;
            txd_reg <= 1'b1;
        end
        else
        begin
            if (ref_en)
                tx_cnt_reg <= tx_tick ? 21'd0 : tx_cnt_reg + 21'd1;
            case (tx_state_reg)
                ST_IDLE:
                begin
                    tx_cnt_reg <= 21'd0;
                    if (fifo_out_valid & fifo_out_ready)
                    begin
                        tx_shift_reg <= fifo_out_data;
                        txd_reg <= 1'b0;
                        tx_state_reg <= ST_START;
                    end
                end
                ST_START:
                    if (tx_tick)
                    begin
                        txd_reg <= tx_shift_reg[0];
                        tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                        tx_bit_reg <= 3'd0;
                        tx_state_reg <= ST_DATA;
                    end
                ST_DATA:
                    if (tx_tick)
                    begin
                        if (tx_bit_reg == 3'd7)
                        begin
                            txd_reg <= 1'b1;
                            tx_state_reg <= ST_STOP;
                        end
                        else
                        begin
                            txd_reg <= tx_shift_reg[0];
                            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                            tx_bit_reg <= tx_bit_reg + 3'd1;
                        end
                    end
                ST_STOP:
                    if (tx_tick)
                    begin
                        if (fifo_out_valid)
                        begin
                            tx_shift_reg <= fifo_out_data;
                            txd_reg <= 1'b0;
                            tx_state_reg <= ST_START;
                        end
                        else
                            tx_state_reg <= ST_IDLE;
                    end
                default:
                begin
                    txd_reg <= 1'b1;
                    tx_state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // driver and receiver enables
    // ---------------------------------------------------------------
    // auto wins if both modes are set; neither means full duplex
    assign drv_en = ctrl_reg[`RDC_CTRL_AUTO] ? tx_busy :
        ctrl_reg[`RDC_CTRL_REQ] ? ctrl_reg[`RDC_CTRL_RTS] :
        1'b1;
    assign DRV_EN_O = drv_en;
    assign RTS_O = ctrl_reg[`RDC_CTRL_RTS];
    assign rx_en = ~(ctrl_reg[`RDC_CTRL_NOECHO] & drv_en);
    assign RX_EN_O = rx_en;

    // ---------------------------------------------------------------
    // receiver
    // ---------------------------------------------------------------
    assign rx_tick = ref_en & (rx_cnt_reg == ((rx_state_reg == ST_START) ?
        half_len : bit_len) - 21'd1);
    assign rx_done = (rx_state_reg == ST_STOP) & rx_tick & rx_s2_reg &
        rx_en;

    always @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
            rx_prev_reg <= 1'b1;
        end
        else
        begin
            rx_s1_reg <= RXD_I;
            rx_s2_reg <= rx_s1_reg;
            rx_prev_reg <= rx_s2_reg;
        end
    end

    always @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            rx_state_reg <= ST_IDLE;
            rx_cnt_reg <= 21'd0;
            rx_bit_reg <= 3'd0;
            rx_shift_reg <= 8'h00;
        end
        else if (!rx_en)
        begin
            // own echo is dropped, including a frame in progress
            rx_state_reg <= ST_IDLE;
            rx_cnt_reg <= 21'd0;
        end
        else
        begin
            if (ref_en)
                rx_cnt_reg <= rx_tick ? 21'd0 : rx_cnt_reg + 21'd1;
            case (rx_state_reg)
                ST_IDLE:
                begin
                    rx_cnt_reg <= 21'd0;
                    if (rx_prev_reg & ~rx_s2_reg)
                        rx_state_reg <= ST_START;
                end
                ST_START:
                    if (rx_tick)
                    begin
                        rx_bit_reg <= 3'd0;
                        rx_state_reg <= rx_s2_reg ? ST_IDLE : ST_DATA;
                    end
                ST_DATA:
                    if (rx_tick)
                    begin
                        rx_shift_reg <= {rx_s2_reg, rx_shift_reg[7:1]};
                        rx_bit_reg <= rx_bit_reg + 3'd1;
                        if (rx_bit_reg == 3'd7)
                            rx_state_reg <= ST_STOP;
                    end
                ST_STOP:
                    if (rx_tick)
                        rx_state_reg <= ST_IDLE;
                default:
                    rx_state_reg <= ST_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // receive holding register and sticky flags
    // ---------------------------------------------------------------
    // set beats clear in the same cycle so no event is lost
    always @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            rx_data_reg <= 8'h00;
            rx_valid_reg <= 1'b0;
            overrun_reg <= 1'b0;
            frame_err_reg <= 1'b0;
        end
        else
        begin
            if (rx_done)
            begin
                rx_data_reg <= rx_shift_reg;
                rx_valid_reg <= 1'b1;
            end
            else if (rx_read)
                rx_valid_reg <= 1'b0;
            if (rx_done & rx_valid_reg & ~rx_read)
                overrun_reg <= 1'b1;
            else if (wr_done & (dp_idx_reg == IDX_STAT) &
                HWDATA_I[`RDC_ST_OVERRUN])
                overrun_reg <= 1'b0;
            if ((rx_state_reg == ST_STOP) & rx_tick & ~rx_s2_reg & rx_en)
                frame_err_reg <= 1'b1;
            else if (wr_done & (dp_idx_reg == IDX_STAT) &
                HWDATA_I[`RDC_ST_FRAMEERR])
                frame_err_reg <= 1'b0;
        end
    end

endmodule // rdc_top

//--- tb/rdc_top_asserts.sv
// Purpose: port checks for rdc_top
// Assumes: control word tracked from bus writes
// Notes:   one clock domain
`timescale 1ns/1ns
`include "rdc_regs.vh"
module rdc_top_asserts (
    // clock and reset
    input logic CLK_I,
    input logic ARST_N_I,
    // bus
    input logic HSEL_I,
    input logic [31:0] HADDR_I,
    input logic [1:0] HTRANS_I,
    input logic HWRITE_I,
    input logic [31:0] HWDATA_I,
    input logic HREADY_I,
    input logic HREADYOUT_O,
    // line
    input logic TXD_O,
    input logic DRV_EN_O,
    input logic RX_EN_O,
    input logic RTS_O,
    input logic BAUD_REF_EN_O
);
    logic [5:0] ctrl_reg;
    logic wr_reg;
    logic [3:0] age_reg;
    logic done_w;
    assign done_w = wr_reg && HREADYOUT_O;
    // age: cycles since the last control write, saturating
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            ctrl_reg <= `RDC_CTRL_RST;
            wr_reg <= 1'b0;
            age_reg <= 4'h0;
        end
        else
        begin
            if (HREADY_I)
                wr_reg <= HSEL_I && HTRANS_I[1] && HWRITE_I
                    && HADDR_I[7:0] == `RDC_CTRL_OFF;
            if (done_w)
                ctrl_reg <= HWDATA_I[5:0];
            age_reg <= done_w ? 4'h0 : age_reg + {3'h0, age_reg != 4'hF};
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);
    property p_req;
        ctrl_reg[1] && !ctrl_reg[0] |-> DRV_EN_O == RTS_O;
    endproperty
    a_req: assert property (p_req)
        else $error("driver enable not following rts");
    property p_auto_on;
        ctrl_reg[0] && !TXD_O |-> DRV_EN_O;
    endproperty
    a_auto_on: assert property (p_auto_on)
        else $error("transmitting with driver off");
    property p_start;
        $rose(DRV_EN_O) && ctrl_reg[0] && age_reg > 4'h1 |-> !TXD_O;
    endproperty
    a_start: assert property (p_start)
        else $error("driver on without start bit");
    property p_stop;
        $fell(DRV_EN_O) && ctrl_reg[0] && age_reg > 4'h1
            |-> TXD_O && $past(TXD_O) && $past(TXD_O, 8);
    endproperty
    a_stop: assert property (p_stop)
        else $error("driver off before stop bit done");
    property p_echo;
        !ctrl_reg[2] |-> RX_EN_O;
    endproperty
    a_echo: assert property (p_echo)
        else $error("receiver off with echo allowed");
    property p_noecho;
        ctrl_reg[2] && DRV_EN_O |-> !RX_EN_O;
    endproperty
    a_noecho: assert property (p_noecho)
        else $error("receiver on while driving");
    property p_div4;
        BAUD_REF_EN_O && ctrl_reg[4:3] == 2'b10 && age_reg == 4'hF
            |-> $past(BAUD_REF_EN_O, 4) && !$past(BAUD_REF_EN_O)
            && !$past(BAUD_REF_EN_O, 2) && !$past(BAUD_REF_EN_O, 3);
    endproperty
    a_div4: assert property (p_div4)
        else $error("reference not every fourth cycle");
    property p_undivided_clock_setting;
        ctrl_reg[4:3] == 2'b01 && age_reg > 4'h3 |-> BAUD_REF_EN_O;
    endproperty
    a_undivided_clock_setting: assert property (p_undivided_clock_setting)
        else $error("reference missing in undivided mode");
    property p_badclk;
        ctrl_reg[4] == ctrl_reg[3] && age_reg > 4'h3 |-> !BAUD_REF_EN_O;
    endproperty
    a_badclk: assert property (p_badclk)
        else $error("reference runs with invalid clock choice");
    c_auto: cover property ($rose(DRV_EN_O) && ctrl_reg[0]);
    c_stall: cover property (!HREADYOUT_O);
    c_req: cover property (ctrl_reg[1] && $rose(RTS_O));
endmodule // rdc_top_asserts

//--- tb/rdc_peer.sv
// Purpose: peer node on the shared two-wire bus
// Assumes: bias resistors pull an idle line to mark
// Notes:   receives and sends 8N1 at bitc clocks a bit
`timescale 1ns/1ns
module rdc_peer (
    // clock
    input logic clk_i,
    // device side
    input logic txd_i,
    input logic drv_en_i,
    // resolved wire
    output wire line_o
);
    int bitc = 16;
    int n_got = 0;
    logic en = 1'b0;
    logic d = 1'b1;
    logic [7:0] got [16];
    logic [7:0] sh;
    assign line_o = drv_en_i ? txd_i : (en ? d : 1'b1);
    always
    begin
        @(negedge line_o);
        repeat (bitc / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++)
        begin
            repeat (bitc) @(posedge clk_i);
            sh[i] = line_o;
        end
        repeat (bitc) @(posedge clk_i);
        got[n_got % 16] = sh;
        n_got = n_got + 1;
    end
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        wait (drv_en_i === 1'b0);
        @(posedge clk_i);
        en <= 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            d <= f[i];
            repeat (bitc) @(posedge clk_i);
        end
        en <= 1'b0;
    endtask
endmodule // rdc_peer

//--- tb/testbench.sv
// Purpose: self-checking bench for rdc_top
// Assumes: device and peer share one two-wire bus
// Notes:   random bytes from a fixed seed
`timescale 1ns/1ns
`include "rdc_regs.vh"
module testbench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b1;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] rdv;
    logic [1:0] modes [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
    wire [31:0] hrdata;
    wire hready, hresp, txd, drv_en, rx_en, rts, bref, line;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    integer seed = 81102;
    initial forever #5 clk = ~clk;
    rdc_top #(.FIFO_DEPTH(8), .FIFO_AW(3)) u_dut (
        .CLK_I(clk), .ARST_N_I(arst_n), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
        .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(hresp), .TXD_O(txd), .DRV_EN_O(drv_en),
        .RXD_I(line), .RX_EN_O(rx_en), .RTS_O(rts), .BAUD_REF_EN_O(bref));
    rdc_peer u_peer (.clk_i(clk), .txd_i(txd), .drv_en_i(drv_en),
        .line_o(line));
    task test_done;
        if (n_errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_errors = n_errors + 1;
            test_done();
        end
    end
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] s);
        compares = compares + 1;
        if (s !== e)
        begin
            n_errors = n_errors + 1;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // single transfer; waits on hready, no fixed latency assumed
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        chk("hresp", 1'b0, hresp);
    endtask
    function automatic int bit_cycles(input logic [5:0] c, input int dv);
        return dv * `RDC_OVERSAMPLE * (c[3] ? 1 : `RDC_PRESCALE_FOUR);
    endfunction
    function automatic int pulses(input logic [1:0] m, input int n);
        return (m == 2'b01) ? n : (m == 2'b10) ? n / 4 : 0;
    endfunction
    task automatic tx_run(input logic [5:0] c, input int dv, input int nb);
        logic [7:0] b [16];
        logic [7:0] x;
        ahb(1'b1, `RDC_CTRL_OFF, {26'h0, c}, rdv);
        ahb(1'b1, `RDC_DIVISOR_OFF, dv, rdv);
        u_peer.bitc = bit_cycles(c, dv);
        u_peer.n_got = 0;
        for (int i = 0; i < nb; i++)
        begin
            x = $random(seed);
            b[i] = x;
            if (i == 9)
            begin
                ahb(1'b0, `RDC_STATUS_OFF, 0, rdv);
                chk("fifo full", 1'b1, rdv[6]);
            end
            ahb(1'b1, `RDC_TXDATA_OFF, {24'h0, x}, rdv);
        end
        wait (u_peer.n_got == nb);
        wait (drv_en === 1'b0);
        for (int i = 0; i < nb; i++)
            chk("peer byte", b[i], u_peer.got[i]);
        ahb(1'b0, `RDC_STATUS_OFF, 0, rdv);
        chk("rx valid", !c[2], rdv[2]);
        ahb(1'b0, `RDC_RXDATA_OFF, 0, rdv);
        if (!c[2])
            chk("echo byte", x, rdv[7:0]);
    endtask
    initial
    begin
        int dv;
        logic [31:0] n;
        logic [7:0] x;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        ahb(1'b0, `RDC_CTRL_OFF, 0, rdv);
        chk("ctrl reset", 32'h0000_0010, rdv);
        ahb(1'b0, `RDC_DIVISOR_OFF, 0, rdv);
        chk("divisor reset", 32'h0000_0001, rdv);
        ahb(1'b0, 8'h14, 0, rdv);
        chk("unmapped", 32'h0000_0000, rdv);
        foreach (modes[k])
        begin
            ahb(1'b1, `RDC_CTRL_OFF, {27'h0, modes[k], 3'h0}, rdv);
            repeat (16) @(posedge clk);
            n = 0;
            repeat (40)
            begin
                @(posedge clk);
                n = n + bref;
            end
            chk("ref pulses", pulses(modes[k], 40), n);
            ahb(1'b0, `RDC_STATUS_OFF, 0, rdv);
            chk("clock bad", modes[k][0] == modes[k][1], rdv[5]);
        end
        tx_run(6'h09, 1, 10);
        tx_run(6'h15, 1, 1);
        dv = 2 + ($random(seed) & 1);
        tx_run(6'h09, dv, 2);
        // request mode, rts low: the peer may talk
        ahb(1'b1, `RDC_CTRL_OFF, 32'h0000_000A, rdv);
        @(posedge clk);
        chk("drv off", 1'b0, drv_en);
        x = $random(seed);
        u_peer.send(x);
        ahb(1'b0, `RDC_RXDATA_OFF, 0, rdv);
        chk("peer to device", x, rdv[7:0]);
        ahb(1'b1, `RDC_CTRL_OFF, 32'h0000_002E, rdv);
        @(posedge clk);
        chk("drv on", 1'b1, drv_en);
        chk("rts", 1'b1, rts);
        chk("rx off", 1'b0, rx_en);
        ahb(1'b0, `RDC_STATUS_OFF, 0, rdv);
        chk("fifo empty", 1'b1, rdv[7]);
        test_done();
    end
endmodule // testbench
bind rdc_top rdc_top_asserts u_chk (
    .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .HSEL_I(HSEL_I),
    .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
    .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
    .HREADYOUT_O(HREADYOUT_O), .TXD_O(TXD_O), .DRV_EN_O(DRV_EN_O),
    .RX_EN_O(RX_EN_O), .RTS_O(RTS_O), .BAUD_REF_EN_O(BAUD_REF_EN_O));
